// *** inc/eeprom_wp_pkg.sv ***
// Shared constants of the serial EEPROM write-protection block.
package eeprom_wp_pkg;
    localparam int ADDR_W = 13;
    localparam int DATA_W = 8;
    localparam int PAGE_W = 5;
    localparam int BITS_W = 10;
    localparam int TIMER_W = 32;
    // Command codes.
    localparam logic [7:0] WRITE_CMD = 8'h02;
    localparam logic [7:0] LATCH_SET_CMD = 8'h06;
    localparam logic [7:0] LATCH_RESET_CMD = 8'h04;
    localparam logic [7:0] STATUS_WRITE_CMD = 8'h01;
    // Status register bit positions.
    localparam int SR_PIN_EN_BIT = 7;
    localparam int SR_BP_HI_BIT = 3;
    localparam int SR_BP_LO_BIT = 2;
    localparam int SR_LATCH_BIT = 1;
    localparam int SR_BUSY_BIT = 0;
    // Block-protect codes.
    localparam logic [1:0] BP_NONE = 2'h0;
    localparam logic [1:0] BP_QUARTER = 2'h1;
    localparam logic [1:0] BP_HALF = 2'h2;
    localparam logic [1:0] BP_ALL = 2'h3;
    localparam logic [1:0] TOP_QUARTER = 2'h3;
    // Frame lengths in bits.
    localparam logic [BITS_W-1:0] CMD_BITS = 10'h008;
    localparam logic [BITS_W-1:0] SRW_BITS = 10'h010;
    localparam logic [BITS_W-1:0] HDR_BITS = 10'h018;
    localparam logic [BITS_W-1:0] MIN_WRITE_BITS = 10'h020;
    localparam logic [BITS_W-1:0] FIRST_BIT = 10'h001;
    localparam logic [2:0] BYTE_PHASE_ZERO = 3'h0;
    localparam logic [2:0] BIT_STEP = 3'h1;
    localparam logic [PAGE_W-1:0] LAST_IDX = 5'h1f;
    localparam logic [PAGE_W-1:0] IDX_STEP = 5'h01;
    // Reset values; the non-volatile bits start from these in simulation.
    localparam logic PIN_EN_RST = 1'h0;
    localparam logic [1:0] BP_RST = 2'h0;
    localparam logic [2:0] SR_UNUSED = 3'h0;
endpackage

// *** src/spi_frame_capture.sv ***
// Serial-clock front end that captures one command frame and its page data.
`timescale 1ns/100ps
`default_nettype none
module spi_frame_capture (
    // Link pins
    input wire logic i_sck,
    input wire logic i_cs_n,
    input wire logic i_si,
    input wire logic i_rst_n,
    // Page buffer read port
    input wire logic [eeprom_wp_pkg::PAGE_W-1:0] i_rd_idx,
    output logic [eeprom_wp_pkg::DATA_W-1:0] o_rd_data,
    // Captured frame
    output logic [7:0] o_opcode,
    output logic [eeprom_wp_pkg::ADDR_W-1:0] o_addr,
    output logic [eeprom_wp_pkg::DATA_W-1:0] o_sr_data,
    output logic [eeprom_wp_pkg::BITS_W-1:0] o_bits,
    output logic [31:0] o_mask
);
    logic fresh_reg;
    logic [7:0] shift_reg;
    logic [7:0] opcode_reg;
    logic [15:0] addr_reg;
    logic [7:0] sr_data_reg;
    logic [eeprom_wp_pkg::BITS_W-1:0] bits_reg;
    logic [eeprom_wp_pkg::BITS_W-1:0] bits_next;
    logic [eeprom_wp_pkg::PAGE_W-1:0] ptr_reg;
    logic [31:0] mask_reg;
    logic [7:0] byte_now;
    logic byte_done;
    logic [eeprom_wp_pkg::DATA_W-1:0] page_mem [32];

    // The clock stops between frames, so a rising select marks the next start.
    always_ff @(posedge i_sck or posedge i_cs_n or negedge i_rst_n) begin
        if (!i_rst_n) begin
            fresh_reg <= 1'h1;
        end else if (i_cs_n) begin
            fresh_reg <= 1'h1;
        end else begin
            fresh_reg <= 1'h0;
        end
    end

    always_comb begin
        byte_now = {shift_reg[6:0], i_si};
        if (fresh_reg) begin
            bits_next = eeprom_wp_pkg::FIRST_BIT;
        end else if (&bits_reg[eeprom_wp_pkg::BITS_W-1:3]) begin
            bits_next = {bits_reg[eeprom_wp_pkg::BITS_W-1:3], bits_reg[2:0] + 3'h1};
        end else begin
            bits_next = bits_reg + eeprom_wp_pkg::FIRST_BIT;
        end
        byte_done = (bits_next >= eeprom_wp_pkg::MIN_WRITE_BITS)
            && (bits_next[2:0] == eeprom_wp_pkg::BYTE_PHASE_ZERO);
    end

    // Bits are taken on the rising serial clock, most significant first.
    always_ff @(posedge i_sck or negedge i_rst_n) begin
        if (!i_rst_n) begin
            shift_reg <= 8'h00;
            opcode_reg <= 8'h00;
            addr_reg <= 16'h0000;
            sr_data_reg <= 8'h00;
            bits_reg <= 10'h000;
            ptr_reg <= 5'h00;
            mask_reg <= 32'h0000_0000;
        end else if (!i_cs_n) begin
            shift_reg <= byte_now;
            bits_reg <= bits_next;
            if (fresh_reg) begin
                mask_reg <= 32'h0000_0000;
            end
            if (bits_next == eeprom_wp_pkg::CMD_BITS) begin
                opcode_reg <= byte_now;
            end
            if (bits_next > eeprom_wp_pkg::CMD_BITS && bits_next <= eeprom_wp_pkg::HDR_BITS) begin
                addr_reg <= {addr_reg[14:0], i_si};
            end
            if (bits_next == eeprom_wp_pkg::HDR_BITS) begin
                ptr_reg <= {addr_reg[3:0], i_si};
            end
            if (bits_next == eeprom_wp_pkg::SRW_BITS) begin
                sr_data_reg <= byte_now;
            end
            // Bytes past the page end wrap and overwrite earlier ones.
            if (byte_done) begin
                mask_reg[ptr_reg] <= 1'h1;
                ptr_reg <= ptr_reg + eeprom_wp_pkg::IDX_STEP;
            end
        end
    end

    always_ff @(posedge i_sck) begin
        if (!i_cs_n && byte_done) begin
            page_mem[ptr_reg] <= byte_now;
        end
    end

    assign o_rd_data = page_mem[i_rd_idx];
    assign o_opcode = opcode_reg;
    assign o_addr = addr_reg[eeprom_wp_pkg::ADDR_W-1:0];
    assign o_sr_data = sr_data_reg;
    assign o_bits = bits_reg;
    assign o_mask = mask_reg;
endmodule // spi_frame_capture
`default_nettype wire

// *** src/serial_eeprom_write_protect.sv ***
// Write and data protection core of a serial EEPROM.
// Summary of operation
// - Four equal segments; block-protect zero protects none.
// - Non-volatile pin-enable bit qualifies the protect pin.
// - Hardware protect when pin low and enable one.
// - Pin high or enable zero: no hardware protect.
// - Hardware protect refuses only status-bit updates.
// - Clear latch protects array and status register.
// - Selected segments never writable; others need latch.
// - Latch is cleared at power-up.
// - Latch clears when a write completes.
// - Writes start only at a whole-byte select rise.
// - Frames during an internal write are not evaluated; one begun during page programming drops the unwritten bytes.
// - Power-up standby with select taken as high.
// - Data output stays high impedance after power-up.
// - Active only after a select falling edge.
// - Status layout: enable 7, protect 3:2, latch 1, busy 0.
// - Latch-reset and an accepted status write clear the latch.
// - Latch commands act regardless of hardware protect.
`timescale 1ns/100ps
`default_nettype none
module serial_eeprom_write_protect #(
    parameter int unsigned WRITE_BUSY_CYCLES = 1000
) (
    // Core clock and reset
    input wire logic I_CORE_CLK,
    input wire logic I_RSTN,
    // Serial link
    input wire logic I_SCK,
    input wire logic I_CS_N,
    input wire logic I_SI,
    output logic O_SO,
    output logic O_SO_OE,
    // Protect pin
    input wire logic I_WP_N,
    // Status and events
    output logic [7:0] O_STATUS,
    output logic O_HW_PROT,
    output logic O_REFUSED,
    output logic O_ABORTED,
    // Array write port
    output logic O_ARR_WE,
    output logic [eeprom_wp_pkg::ADDR_W-1:0] O_ARR_ADDR,
    output logic [eeprom_wp_pkg::DATA_W-1:0] O_ARR_DATA
);
    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_SEL = 5'h02,
        ST_EVAL = 5'h04,
        ST_PROG = 5'h08,
        ST_WAIT = 5'h10
    } state_t;

    localparam int TIMER_W_L = eeprom_wp_pkg::TIMER_W;
    localparam logic [TIMER_W_L-1:0] BUSY_LAST = TIMER_W_L'(WRITE_BUSY_CYCLES - 1);

    state_t state_reg;
    logic cs_meta_reg;
    logic cs_sync_reg;
    logic cs_prev_reg;
    logic wp_meta_reg;
    logic wp_sync_reg;
    logic pin_en_reg;
    logic [1:0] bp_reg;
    logic latch_reg;
    logic [eeprom_wp_pkg::PAGE_W-1:0] idx_reg;
    logic [TIMER_W_L-1:0] timer_reg;
    logic [7:0] status_next;
    logic cs_fall;
    logic hw_prot;
    logic busy;
    logic is_write;
    logic is_srw;
    logic bits_whole;
    logic write_go;
    logic srw_go;
    logic set_go;
    logic reset_go;
    logic refuse;
    logic abort;
    logic busy_done;
    logic [eeprom_wp_pkg::ADDR_W-1:0] prog_addr;
    logic [7:0] opcode;
    logic [eeprom_wp_pkg::ADDR_W-1:0] frame_addr;
    logic [eeprom_wp_pkg::DATA_W-1:0] sr_data;
    logic [eeprom_wp_pkg::BITS_W-1:0] frame_bits;
    logic [31:0] frame_mask;
    logic [eeprom_wp_pkg::DATA_W-1:0] page_byte;

    // Block-protect decode of one array address.
    function automatic logic is_protected(input logic [1:0] bp,
                                          input logic [eeprom_wp_pkg::ADDR_W-1:0] addr);
        logic [1:0] seg;
        seg = addr[eeprom_wp_pkg::ADDR_W-1:eeprom_wp_pkg::ADDR_W-2];
        case (bp)
            eeprom_wp_pkg::BP_NONE: is_protected = 1'h0;
            eeprom_wp_pkg::BP_QUARTER: is_protected = (seg == eeprom_wp_pkg::TOP_QUARTER);
            eeprom_wp_pkg::BP_HALF: is_protected = seg[1];
            default: is_protected = 1'h1;
        endcase
    endfunction

    // The frame registers only move while the serial clock runs under a low
    // select; they are read here once the synchronised select is back high.
    spi_frame_capture spi_frame_capture_i (
        .i_sck(I_SCK),
        .i_cs_n(I_CS_N),
        .i_si(I_SI),
        .i_rst_n(I_RSTN),
        .i_rd_idx(idx_reg),
        .o_rd_data(page_byte),
        .o_opcode(opcode),
        .o_addr(frame_addr),
        .o_sr_data(sr_data),
        .o_bits(frame_bits),
        .o_mask(frame_mask)
    );

    // Select resets to high so the device wakes in standby.
    always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            cs_meta_reg <= 1'h1;
            cs_sync_reg <= 1'h1;
            cs_prev_reg <= 1'h1;
        end else begin
            cs_meta_reg <= I_CS_N;
            cs_sync_reg <= cs_meta_reg;
            cs_prev_reg <= cs_sync_reg;
        end
    end

    always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            wp_meta_reg <= 1'h1;
            wp_sync_reg <= 1'h1;
        end else begin
            wp_meta_reg <= I_WP_N;
            wp_sync_reg <= wp_meta_reg;
        end
    end

    always_comb begin
        cs_fall = cs_prev_reg && !cs_sync_reg;
        hw_prot = pin_en_reg && !wp_sync_reg;
        busy = (state_reg == ST_PROG) || (state_reg == ST_WAIT);
        bits_whole = (frame_bits[2:0] == eeprom_wp_pkg::BYTE_PHASE_ZERO);
        is_write = (opcode == eeprom_wp_pkg::WRITE_CMD);
        is_srw = (opcode == eeprom_wp_pkg::STATUS_WRITE_CMD);
        set_go = (opcode == eeprom_wp_pkg::LATCH_SET_CMD)
            && (frame_bits == eeprom_wp_pkg::CMD_BITS);
        reset_go = (opcode == eeprom_wp_pkg::LATCH_RESET_CMD)
            && (frame_bits == eeprom_wp_pkg::CMD_BITS);
        // A write needs the latch armed and a select rise on a byte boundary.
        write_go = is_write && latch_reg && bits_whole
            && (frame_bits >= eeprom_wp_pkg::MIN_WRITE_BITS);
        srw_go = is_srw && latch_reg && !hw_prot
            && (frame_bits == eeprom_wp_pkg::SRW_BITS);
        abort = (is_write && (frame_bits >= eeprom_wp_pkg::HDR_BITS) && !bits_whole)
            || (is_srw && (frame_bits > eeprom_wp_pkg::CMD_BITS)
                && (frame_bits != eeprom_wp_pkg::SRW_BITS));
        refuse = !abort && ((is_write && !latch_reg
            && (frame_bits >= eeprom_wp_pkg::MIN_WRITE_BITS))
            || (is_srw && (frame_bits == eeprom_wp_pkg::SRW_BITS) && !srw_go));
        busy_done = (state_reg == ST_WAIT) && (timer_reg == BUSY_LAST);
        prog_addr = {frame_addr[eeprom_wp_pkg::ADDR_W-1:eeprom_wp_pkg::PAGE_W], idx_reg};
    end

    // While busy the select is not watched at all, and a frame already under
    // way when the write ends is skipped because no fresh falling edge is seen.
    always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            state_reg <= ST_IDLE;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (cs_fall) begin
                        state_reg <= ST_SEL;
                    end
                end
                ST_SEL: begin
                    if (cs_sync_reg) begin
                        state_reg <= ST_EVAL;
                    end
                end
                ST_EVAL: begin
                    if (write_go) begin
                        state_reg <= ST_PROG;
                    end else if (srw_go) begin
                        state_reg <= ST_WAIT;
                    end else begin
                        state_reg <= ST_IDLE;
                    end
                end
                ST_PROG: begin
                    if (idx_reg == eeprom_wp_pkg::LAST_IDX) begin
                        state_reg <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (busy_done) begin
                        state_reg <= ST_IDLE;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            latch_reg <= 1'h0;
        end else if (state_reg == ST_EVAL && set_go) begin
            latch_reg <= 1'h1;
        end else if (state_reg == ST_EVAL && (reset_go || srw_go)) begin
            latch_reg <= 1'h0;
        end else if (busy_done) begin
            latch_reg <= 1'h0;
        end
    end

    // The protection bits model non-volatile cells but reload the package reset values on reset.
    always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            pin_en_reg <= eeprom_wp_pkg::PIN_EN_RST;
            bp_reg <= eeprom_wp_pkg::BP_RST;
        end else if (state_reg == ST_EVAL && srw_go) begin
            pin_en_reg <= sr_data[eeprom_wp_pkg::SR_PIN_EN_BIT];
            bp_reg <= sr_data[eeprom_wp_pkg::SR_BP_HI_BIT:eeprom_wp_pkg::SR_BP_LO_BIT];
        end
    end

    always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            idx_reg <= 5'h00;
        end else if (state_reg == ST_PROG) begin
            idx_reg <= idx_reg + eeprom_wp_pkg::IDX_STEP;
        end else begin
            idx_reg <= 5'h00;
        end
    end

    always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            timer_reg <= 32'h0000_0000;
        end else if (state_reg == ST_WAIT) begin
            timer_reg <= timer_reg + TIMER_W_L'(1);
        end else begin
            timer_reg <= 32'h0000_0000;
        end
    end

    // Unsent or fenced bytes are dropped; the busy time is the same either way.
    always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            O_ARR_WE <= 1'h0;
            O_ARR_ADDR <= 13'h0000;
            O_ARR_DATA <= 8'h00;
        end else begin
            O_ARR_WE <= (state_reg == ST_PROG) && frame_mask[idx_reg]
                && !is_protected(bp_reg, prog_addr);
            O_ARR_ADDR <= prog_addr;
            O_ARR_DATA <= page_byte;
        end
    end

    always_comb begin
        status_next = {eeprom_wp_pkg::SR_UNUSED, eeprom_wp_pkg::SR_UNUSED[1:0],
                       eeprom_wp_pkg::SR_UNUSED};
        status_next[eeprom_wp_pkg::SR_PIN_EN_BIT] = pin_en_reg;
        status_next[eeprom_wp_pkg::SR_BP_HI_BIT] = bp_reg[1];
        status_next[eeprom_wp_pkg::SR_BP_LO_BIT] = bp_reg[0];
        status_next[eeprom_wp_pkg::SR_LATCH_BIT] = latch_reg;
        status_next[eeprom_wp_pkg::SR_BUSY_BIT] = busy;
    end

    // The read path is not part of this block, so the data pin is never driven.
    always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            O_STATUS <= 8'h00;
            O_HW_PROT <= 1'h0;
            O_REFUSED <= 1'h0;
            O_ABORTED <= 1'h0;
            O_SO <= 1'h0;
            O_SO_OE <= 1'h0;
        end else begin
            O_STATUS <= status_next;
            O_HW_PROT <= hw_prot;
            O_REFUSED <= (state_reg == ST_EVAL) && refuse;
            O_ABORTED <= (state_reg == ST_EVAL) && abort;
            O_SO <= 1'h0;
            O_SO_OE <= 1'h0;
        end
    end
endmodule // serial_eeprom_write_protect
`default_nettype wire

// *** tb/serial_eeprom_write_protect_checker.sv ***
// Concurrent checks on the ports of the write-protection core.
`timescale 1ns/100ps
`default_nettype none
module serial_eeprom_write_protect_checker (
    // Core clock and reset
    input wire logic I_CORE_CLK,
    input wire logic I_RSTN,
    // Protect pin and outputs watched
    input wire logic I_WP_N,
    input wire logic O_SO_OE,
    input wire logic [7:0] O_STATUS,
    input wire logic O_HW_PROT,
    input wire logic O_REFUSED,
    input wire logic O_ABORTED,
    input wire logic O_ARR_WE,
    input wire logic [eeprom_wp_pkg::ADDR_W-1:0] O_ARR_ADDR
);
    default clocking cb @(posedge I_CORE_CLK); endclocking
    default disable iff (!I_RSTN);
    logic hit;
    assign hit = (O_STATUS[3:2] == 2'h3) || (O_STATUS[3:2] == 2'h2 && O_ARR_ADDR[12])
        || (O_STATUS[3:2] == 2'h1 && O_ARR_ADDR[12:11] == 2'h3);
    reset_clear_a: assert property ($rose(I_RSTN) |-> O_STATUS == 8'h00)
        else $error("status not clear after reset");
    so_quiet_a: assert property (O_SO_OE == 1'b0)
        else $error("serial output driven");
    status_pad_a: assert property (O_STATUS[6:4] == 3'h0)
        else $error("unused status bits set");
    // Pin and enable must both have settled, since the pin crosses two flops first.
    hw_on_a: assert property (O_STATUS[7] && $past(O_STATUS[7])
        && !$past(I_WP_N, 3) && !$past(I_WP_N, 4) |-> O_HW_PROT)
        else $error("hardware protect missing");
    hw_off_a: assert property ((!O_STATUS[7] && !$past(O_STATUS[7]))
        || ($past(I_WP_N, 3) && $past(I_WP_N, 4)) |-> !O_HW_PROT)
        else $error("hardware protect without cause");
    write_latch_a: assert property (O_ARR_WE |-> O_STATUS[1] && O_STATUS[0])
        else $error("array write without latch");
    block_guard_a: assert property (O_ARR_WE |-> !hit)
        else $error("write into protected segment");
    latch_done_a: assert property ($fell(O_STATUS[0]) |-> !O_STATUS[1])
        else $error("latch left set after write");
    pulse_one_a: assert property ((O_REFUSED || O_ABORTED)
        |-> !(O_REFUSED && O_ABORTED) ##1 (!O_REFUSED && !O_ABORTED))
        else $error("event pulse malformed");
    cover property (O_ARR_WE);
    cover property (O_REFUSED);
    cover property (O_ABORTED);
    cover property (O_HW_PROT);
endmodule // serial_eeprom_write_protect_checker
bind serial_eeprom_write_protect serial_eeprom_write_protect_checker checker_i (
    .I_CORE_CLK(I_CORE_CLK), .I_RSTN(I_RSTN), .I_WP_N(I_WP_N), .O_SO_OE(O_SO_OE),
    .O_STATUS(O_STATUS), .O_HW_PROT(O_HW_PROT), .O_REFUSED(O_REFUSED),
    .O_ABORTED(O_ABORTED), .O_ARR_WE(O_ARR_WE), .O_ARR_ADDR(O_ARR_ADDR));
`default_nettype wire

// *** tb/spi_host_model.sv ***
// Host-side serial controller model that frames commands onto the link.
`timescale 1ns/100ps
`default_nettype none
module spi_host_model (
    // Link pins
    output logic o_sck,
    output logic o_cs_n,
    output logic o_si
);
    initial begin
        o_sck = 1'b0;
        o_cs_n = 1'b1;
        o_si = 1'b0;
    end
    // The clock stands low between frames, so no stray edge can shift a bit in.
    task automatic frame(input logic [63:0] v, input int n);
        #3 o_cs_n = 1'b0;
        for (int k = n - 1; k >= 0; k--) begin
            o_si = v[k];
            #16 o_sck = 1'b1;
            #16 o_sck = 1'b0;
        end
        #16 o_cs_n = 1'b1;
        o_si = ~o_si;
        #80;
    endtask
endmodule // spi_host_model
`default_nettype wire

// *** tb/tb_serial_eeprom_write_protect.sv ***
// Self-checking bench of the write-protection core.
`timescale 1ns/100ps
`default_nettype none
module tb_serial_eeprom_write_protect;
    logic clk, rst_n, wp_n, sck, cs_n, si, so, so_oe, hw_prot, refused, aborted, arr_we;
    logic [7:0] status;
    logic [eeprom_wp_pkg::ADDR_W-1:0] arr_addr;
    logic [eeprom_wp_pkg::DATA_W-1:0] arr_data;
    logic [20:0] we_q[$];
    int n_fail = 0;
    int tests_run = 0;
    int n_ref = 0;
    int n_abt = 0;
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    serial_eeprom_write_protect #(.WRITE_BUSY_CYCLES(8)) serial_eeprom_write_protect_i (
        .I_CORE_CLK(clk), .I_RSTN(rst_n), .I_SCK(sck), .I_CS_N(cs_n), .I_SI(si),
        .O_SO(so), .O_SO_OE(so_oe), .I_WP_N(wp_n), .O_STATUS(status), .O_HW_PROT(hw_prot),
        .O_REFUSED(refused), .O_ABORTED(aborted), .O_ARR_WE(arr_we),
        .O_ARR_ADDR(arr_addr), .O_ARR_DATA(arr_data));
    spi_host_model spi_host_model_i (.o_sck(sck), .o_cs_n(cs_n), .o_si(si));
    always @(posedge clk) begin
        if (arr_we === 1'b1) we_q.push_back({arr_addr, arr_data});
        if (refused === 1'b1) n_ref++;
        if (aborted === 1'b1) n_abt++;
    end
    task automatic check(input string name, input logic [20:0] seen, input logic [20:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic expect_we(input string name, input logic [20:0] exp);
        check(name, we_q.size() > 0 ? we_q.pop_front() : 21'h0, exp);
    endtask
    // Evaluation lands a few cycles after select rises; then busy is waited out.
    task automatic send(input logic [63:0] v, input int n);
        int k;
        spi_host_model_i.frame(v, n);
        repeat (9) @(posedge clk);
        k = 0;
        while (status[0] !== 1'b0 && k < 200) begin
            @(posedge clk);
            k++;
        end
        check("busy wait", 21'(k == 200), 21'h0);
    endtask
    task automatic cmd(input logic [7:0] op);
        send({56'h0, op}, 8);
    endtask
    task automatic srw(input logic [7:0] d);
        send({48'h0, eeprom_wp_pkg::STATUS_WRITE_CMD, d}, 16);
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        send({32'h0, eeprom_wp_pkg::WRITE_CMD, a, d}, 32);
    endtask
    function automatic logic blocked(input logic [1:0] c, input logic [1:0] a);
        return c == 2'h3 || (c == 2'h2 && a[1]) || (c == 2'h1 && a == 2'h3);
    endfunction
    initial begin
        repeat (40000) @(posedge clk);
        n_fail++;
        final_report();
    end
    initial begin
        rst_n = 1'b0;
        wp_n = 1'b1;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        check("status after reset", 21'(status), 21'h0);
        check("so enable", 21'(so_oe), 21'h0);
        check("so pin", 21'(so), 21'h0);
        wr(16'h0040, 8'h11);
        check("refused unarmed", 21'(n_ref), 21'h1);
        check("no write unarmed", 21'(we_q.size()), 21'h0);
        cmd(eeprom_wp_pkg::LATCH_SET_CMD);
        check("latch set", 21'(status), 21'h2);
        cmd(eeprom_wp_pkg::LATCH_RESET_CMD);
        check("latch reset", 21'(status), 21'h0);
        cmd(eeprom_wp_pkg::LATCH_SET_CMD);
        send({24'h0, eeprom_wp_pkg::WRITE_CMD, 16'h1ffe, 16'ha53c}, 40);
        expect_we("page slot 30", {13'h1ffe, 8'ha5});
        expect_we("page slot 31", {13'h1fff, 8'h3c});
        check("latch after write", 21'(status), 21'h0);
        cmd(eeprom_wp_pkg::LATCH_SET_CMD);
        send({31'h0, eeprom_wp_pkg::WRITE_CMD, 16'h0000, 8'h77, 1'b1}, 33);
        check("aborted", 21'(n_abt), 21'h1);
        check("no abort write", 21'(we_q.size()), 21'h0);
        // The second frame falls inside the busy time and must leave no trace.
        spi_host_model_i.frame({32'h0, eeprom_wp_pkg::WRITE_CMD, 16'h0123, 8'h5a}, 32);
        send({56'h0, eeprom_wp_pkg::LATCH_SET_CMD}, 8);
        expect_we("write before busy frame", {13'h0123, 8'h5a});
        check("busy frame ignored", 21'(status), 21'h0);
        for (int c = 1; c < 4; c++) begin
            cmd(eeprom_wp_pkg::LATCH_SET_CMD);
            srw({4'h0, c[1:0], 2'h0});
            check("protect code", 21'(status), 21'({c[1:0], 2'h0}));
            for (int a = 0; a < 4; a++) begin
                cmd(eeprom_wp_pkg::LATCH_SET_CMD);
                wr({3'h0, a[1:0], 11'h005}, {6'h10, a[1:0]});
                if (!blocked(c[1:0], a[1:0])) begin
                    expect_we("open segment", {a[1:0], 11'h005, 6'h10, a[1:0]});
                end
                check("segment kept", 21'(we_q.size()), 21'h0);
            end
        end
        cmd(eeprom_wp_pkg::LATCH_SET_CMD);
        srw(8'h80);
        wp_n <= 1'b0;
        repeat (6) @(posedge clk);
        check("hw protect on", 21'(hw_prot), 21'h1);
        cmd(eeprom_wp_pkg::LATCH_SET_CMD);
        check("latch under hw", 21'(status), 21'h82);
        srw(8'h0c);
        check("status held", 21'(status), 21'h82);
        check("refused status", 21'(n_ref), 21'h2);
        wr(16'h0010, 8'h99);
        expect_we("array under hw", {13'h0010, 8'h99});
        wp_n <= 1'b1;
        repeat (6) @(posedge clk);
        check("hw protect off", 21'(hw_prot), 21'h0);
        cmd(eeprom_wp_pkg::LATCH_SET_CMD);
        srw(8'h00);
        check("status cleared", 21'(status), 21'h0);
        final_report();
    end
endmodule // tb_serial_eeprom_write_protect
`default_nettype wire
